/* core/irq_pkg.sv */
// Purpose: Shared constants and types of the nested interrupt controller.
// Assumes: Eight-bit register port, sixteen-bit vector addresses.
// Notes: Priority encodings follow the condition code bit pair.
package irq_pkg;
  // Priority bit pair encodings, lowest to highest level.
  localparam logic [1:0] LVL_0 = 2'h2;
  localparam logic [1:0] LVL_1 = 2'h1;
  localparam logic [1:0] LVL_2 = 2'h0;
  localparam logic [1:0] LVL_3 = 2'h3;
  localparam int CC_HI = 5;
  localparam int CC_LO = 3;
  localparam logic [7:0] CC_RESET = 8'hEA;
  localparam logic [7:0] ISPR_RESET = 8'hFF;
  localparam int FIELD_W = 2;
  localparam int FIELDS_PER_REG = 4;
  localparam int N_ISPR = 4;
  localparam int VEC_IDX_W = 4;
  localparam int CTX_W = 40;
  // Register port offsets.
  localparam logic [3:0] A_ISPR0 = 4'h0;
  localparam logic [3:0] A_EXT_INT_SENSITIVITY_CTRL = 4'h4;
  localparam logic [3:0] A_PSEL0 = 4'h5;
  localparam logic [3:0] A_PEND_LO = 4'h9;
  localparam logic [3:0] A_PEND_HI = 4'hA;
  localparam logic [3:0] A_CC = 4'hB;
  localparam logic [3:0] A_STATUS = 4'hC;
  // Vector addresses at the top of the map.
  localparam logic [15:0] VEC_RESET = 16'hFFFE;
  localparam logic [15:0] VEC_TRAP = 16'hFFFC;
  localparam logic [15:0] VEC_FIRST = 16'hFFFA;
  // External line sensitivity per two-bit field.
  localparam logic [1:0] EXT_LOW = 2'h0;
  localparam logic [1:0] EXT_RISE = 2'h1;
  localparam logic [1:0] EXT_FALL = 2'h2;
  localparam logic [1:0] EXT_BOTH = 2'h3;
  typedef enum logic [1:0] {st_reset, st_run, st_halt, st_wait} state_t;
endpackage

/* core/nested_priority_interrupt_ctrl.sv */
// Purpose: Nested priority interrupt controller beside an 8-bit core.
// Assumes: One clock mclk; inputs other than rstn synchronous; CPU pulses strobes.
// Notes: Context stack is internal; overflow is silent.
// What this block does
// - Priority level lives in CC bits 5, 3.
// - Four nesting levels, up to sixteen vectors.
// - Vectors fixed from FFE0h to FFFFh.
// - Current instruction completes before entry.
// - Entry stacks PC, X, A and CC.
// - Entry loads vector level, then vector.
// - Return restores context including priority bits.
// - Highest software level wins first.
// - Ties resolved by fixed hardware order.
// - Unique hardware order gives one winner.
// - Unserviced requests stay latched until highest, except low-level external lines.
// - Reset, trap ignore mask; set level three.
// - Reset leaves Halt; trap is taken in Run only.
// - Trap instruction raises trap entry.
// - Reset has topmost priority, level three.
// - Maskable needs enable and higher level.
// - External lines wake Halt; sensitivity programmable.
// - Edge latch clears on handler entry.
// - Selected pins of one group ORed.
// - Peripheral request needs flag and enable.
// - Clear sequence discards a pending request.
// - All wake Wait; capable ones wake Halt.
// - Halt exit serves a capable source first.
// - Level codes 10, 01, 00, 11.
// - Vector levels reset to ones; ISPR3 top ones.
// - Level zero writes to a field ignored.
//
// The register offsets and the strobed register port were decided locally.
`timescale 1ns/1ns
module nested_priority_interrupt_ctrl #(
  parameter int NV = 14,
  parameter int N_EXT = 4,
  parameter int GROUP_W = 4,
  parameter int EXT_BASE = 2,
  parameter logic [NV-1:0] HALT_CAP = 14'h013F,
  parameter int STACK_DEPTH = 8
) (
  input wire logic mclk, // system clock
  input wire logic rstn, // async reset, active low
  input wire logic [3:0] reg_addr, // register offset
  input wire logic [7:0] reg_wdata, // register write data
  input wire logic reg_wr, // register write strobe
  input wire logic reg_rd, // register read strobe
  output logic [7:0] reg_rdata, // read data, cycle after strobe
  input wire logic instr_end, // current instruction completes
  input wire logic trap_exec, // trap instruction completes
  input wire logic interrupt_return_exec, // interrupt_return executes
  input wire logic cc_wr, // core writes condition code
  input wire logic [7:0] cc_wdata, // value of that write
  input wire logic halt_enter, // core enters Halt
  input wire logic wait_enter, // core enters Wait
  input wire logic [15:0] pc_in, // program counter to stack
  input wire logic [7:0] x_in, // index register to stack
  input wire logic [7:0] a_in, // accumulator to stack
  input wire logic [N_EXT*GROUP_W-1:0] ext_pins, // external pins
  input wire logic [NV-1:0] periph_flag, // peripheral status flags
  input wire logic [NV-1:0] periph_en, // peripheral enable bits
  input wire logic [NV-1:0] periph_clear, // clear sequence done
  output logic [7:0] condition_code_reg, // current CC
  output logic [15:0] vector_addr, // vector to fetch from
  output logic vector_valid, // vector load pulse
  output logic restore_valid, // context restore pulse
  output logic [15:0] restore_pc, // restored program counter
  output logic [7:0] restore_x, // restored index register
  output logic [7:0] restore_a, // restored accumulator
  output logic halted, // core held in Halt
  output logic waiting // core held in Wait
);
  localparam int SPW = $clog2(STACK_DEPTH) + 1;
  localparam int VW = irq_pkg::VEC_IDX_W;

  typedef struct packed {
    irq_pkg::state_t st;
    logic [NV-1:0][1:0] ispr;
    logic [2*N_EXT-1:0] ext_int_sensitivity_ctrl;
    logic [N_EXT-1:0][GROUP_W-1:0] psel;
    logic [N_EXT-1:0] ext_prev;
    logic [N_EXT-1:0] ext_lat;
    logic [NV-1:0] per_lat;
    logic [7:0] cc;
    logic [SPW-1:0] sp;
    logic [STACK_DEPTH-1:0][irq_pkg::CTX_W-1:0] stk;
    logic [15:0] vec_addr;
    logic vec_v;
    logic rest_v;
    logic [15:0] rest_pc;
    logic [7:0] rest_x;
    logic [7:0] rest_a;
    logic [7:0] rdata;
    logic halted;
    logic waiting;
  } state_s_t;

  state_s_t s;
  state_s_t n;

  function automatic logic [1:0] rank(input logic [1:0] e);
    case (e)
      irq_pkg::LVL_0: rank = 2'h0;
      irq_pkg::LVL_1: rank = 2'h1;
      irq_pkg::LVL_2: rank = 2'h2;
      default: rank = 2'h3;
    endcase
  endfunction

  // Walk from the lowest hardware priority up, so that among equal
  // software levels the lowest index, the highest hardware one, wins.
  function automatic logic [VW:0] arb(input logic [NV-1:0] el,
                                      input logic [NV-1:0][1:0] pr);
    logic f;
    logic [VW-1:0] w;
    logic [1:0] br;
    f = 1'b0;
    w = '0;
    br = '0;
    for (int v = NV - 1; v >= 0; v--) begin
      if (el[v] && (!f || rank(pr[v]) >= br)) begin
        f = 1'b1;
        w = VW'(v);
        br = rank(pr[v]);
      end
    end
    return {f, w};
  endfunction

  logic [1:0] cur_lvl;
  logic [N_EXT-1:0] line_hi;
  logic [N_EXT-1:0] line_lo;
  logic [N_EXT-1:0] ext_edge;
  logic [NV-1:0] pend;
  logic [NV-1:0] elig;
  logic [VW:0] win;
  logic [VW:0] hwin;
  logic take_trap;
  logic take_mask;
  logic [VW-1:0] take_v;
  logic [1:0] take_lvl;
  logic [irq_pkg::CTX_W-1:0] top_ctx;

  assign cur_lvl = {s.cc[irq_pkg::CC_HI], s.cc[irq_pkg::CC_LO]};

  always_comb begin
    for (int k = 0; k < N_EXT; k++) begin
      line_hi[k] = |(ext_pins[k*GROUP_W +: GROUP_W] & s.psel[k]);
      line_lo[k] = |(~ext_pins[k*GROUP_W +: GROUP_W] & s.psel[k]);
      case (s.ext_int_sensitivity_ctrl[2*k +: 2])
        irq_pkg::EXT_RISE: ext_edge[k] = line_hi[k] & ~s.ext_prev[k];
        irq_pkg::EXT_FALL: ext_edge[k] = ~line_hi[k] & s.ext_prev[k];
        irq_pkg::EXT_BOTH: ext_edge[k] = line_hi[k] ^ s.ext_prev[k];
        default: ext_edge[k] = 1'b0;
      endcase
    end
    for (int v = 0; v < NV; v++) begin
      if (v >= EXT_BASE && v < EXT_BASE + N_EXT) begin
        if (s.ext_int_sensitivity_ctrl[2*(v-EXT_BASE) +: 2] == irq_pkg::EXT_LOW) begin
          pend[v] = line_lo[v-EXT_BASE];
        end else begin
          pend[v] = s.ext_lat[v-EXT_BASE];
        end
      end else begin
        pend[v] = s.per_lat[v];
      end
      elig[v] = pend[v] && rank(s.ispr[v]) > rank(cur_lvl);
    end
  end

  assign win = arb(elig, s.ispr);
  assign hwin = arb(elig & HALT_CAP, s.ispr);
  assign take_trap = s.st == irq_pkg::st_run && trap_exec;
  assign take_mask = !take_trap &&
    ((s.st == irq_pkg::st_run && instr_end && !interrupt_return_exec && win[VW]) ||
     (s.st == irq_pkg::st_wait && win[VW]) ||
     (s.st == irq_pkg::st_halt && hwin[VW]));
  assign take_v = s.st == irq_pkg::st_halt ? hwin[VW-1:0] : win[VW-1:0];
  assign take_lvl = s.ispr[take_v];
  assign top_ctx = s.stk[s.sp - SPW'(1)];

  always_comb begin
    n = s;
    n.vec_v = 1'b0;
    n.rest_v = 1'b0;
    n.rdata = '0;
    // Edge latches: a new edge wins over the entry clear.
    for (int k = 0; k < N_EXT; k++) begin
      n.ext_prev[k] = line_hi[k];
      if (take_mask && int'(take_v) == EXT_BASE + k) begin
        n.ext_lat[k] = 1'b0;
      end
      if (ext_edge[k]) begin
        n.ext_lat[k] = 1'b1;
      end
    end
    for (int v = 0; v < NV; v++) begin
      if (periph_clear[v]) begin
        n.per_lat[v] = 1'b0;
      end
      if (periph_flag[v] && periph_en[v]) begin
        n.per_lat[v] = 1'b1;
      end
    end
    // Register writes.
    if (reg_wr) begin
      if (reg_addr < irq_pkg::A_EXT_INT_SENSITIVITY_CTRL) begin
        for (int v = 0; v < NV; v++) begin
          if (int'(reg_addr) == v / irq_pkg::FIELDS_PER_REG &&
              reg_wdata[irq_pkg::FIELD_W*(v%irq_pkg::FIELDS_PER_REG)
                        +: irq_pkg::FIELD_W] != irq_pkg::LVL_0) begin
            n.ispr[v] = reg_wdata[irq_pkg::FIELD_W*
                        (v%irq_pkg::FIELDS_PER_REG) +: irq_pkg::FIELD_W];
          end
        end
      end else if (reg_addr == irq_pkg::A_EXT_INT_SENSITIVITY_CTRL) begin
        n.ext_int_sensitivity_ctrl = reg_wdata[2*N_EXT-1:0];
      end else begin
        for (int k = 0; k < N_EXT; k++) begin
          if (int'(reg_addr) == int'(irq_pkg::A_PSEL0) + k) begin
            n.psel[k] = reg_wdata[GROUP_W-1:0];
          end
        end
      end
    end
    // Register reads; unmapped offsets return zero.
    if (reg_rd) begin
      if (reg_addr < irq_pkg::A_EXT_INT_SENSITIVITY_CTRL) begin
        for (int j = 0; j < irq_pkg::FIELDS_PER_REG; j++) begin
          if (int'(reg_addr) * irq_pkg::FIELDS_PER_REG + j < NV) begin
            n.rdata[irq_pkg::FIELD_W*j +: irq_pkg::FIELD_W] =
              s.ispr[int'(reg_addr) * irq_pkg::FIELDS_PER_REG + j];
          end else begin
            n.rdata[irq_pkg::FIELD_W*j +: irq_pkg::FIELD_W] = '1;
          end
        end
      end else if (reg_addr == irq_pkg::A_EXT_INT_SENSITIVITY_CTRL) begin
        n.rdata = 8'(s.ext_int_sensitivity_ctrl);
      end else if (reg_addr == irq_pkg::A_PEND_LO) begin
        n.rdata = 8'(pend);
      end else if (reg_addr == irq_pkg::A_PEND_HI) begin
        n.rdata = 8'(pend >> 8);
      end else if (reg_addr == irq_pkg::A_CC) begin
        n.rdata = s.cc;
      end else if (reg_addr == irq_pkg::A_STATUS) begin
        n.rdata = 8'({s.halted, s.waiting, s.sp});
      end else begin
        for (int k = 0; k < N_EXT; k++) begin
          if (int'(reg_addr) == int'(irq_pkg::A_PSEL0) + k) begin
            n.rdata = 8'(s.psel[k]);
          end
        end
      end
    end
    // Core sequencing.
    case (s.st)
      irq_pkg::st_reset: begin
        // Reset vector: no stacking, level three.
        n.cc[irq_pkg::CC_HI] = irq_pkg::LVL_3[1];
        n.cc[irq_pkg::CC_LO] = irq_pkg::LVL_3[0];
        n.vec_addr = irq_pkg::VEC_RESET;
        n.vec_v = 1'b1;
        n.st = irq_pkg::st_run;
      end
      irq_pkg::st_run: begin
        if (interrupt_return_exec && !take_trap && s.sp != '0) begin
          n.sp = s.sp - SPW'(1);
          {n.rest_pc, n.rest_x, n.rest_a, n.cc} = top_ctx;
          n.rest_v = 1'b1;
        end else if (cc_wr && !take_trap) begin
          n.cc = cc_wdata;
        end else if (halt_enter && !take_trap) begin
          n.cc[irq_pkg::CC_HI] = irq_pkg::LVL_0[1];
          n.cc[irq_pkg::CC_LO] = irq_pkg::LVL_0[0];
          n.st = irq_pkg::st_halt;
        end else if (wait_enter && !take_trap) begin
          n.cc[irq_pkg::CC_HI] = irq_pkg::LVL_0[1];
          n.cc[irq_pkg::CC_LO] = irq_pkg::LVL_0[0];
          n.st = irq_pkg::st_wait;
        end
      end
      default: begin
        if (take_mask) begin
          n.st = irq_pkg::st_run;
        end
      end
    endcase
    // Entry: stack old context, load level, then vector.
    if (take_trap || take_mask) begin
      // A full stack drops the context silently, as on the real core.
      if (s.sp < SPW'(STACK_DEPTH)) begin
        n.stk[s.sp] = {pc_in, x_in, a_in, s.cc};
        n.sp = s.sp + SPW'(1);
      end
      if (take_trap) begin
        n.cc[irq_pkg::CC_HI] = irq_pkg::LVL_3[1];
        n.cc[irq_pkg::CC_LO] = irq_pkg::LVL_3[0];
        n.vec_addr = irq_pkg::VEC_TRAP;
      end else begin
        n.cc[irq_pkg::CC_HI] = take_lvl[1];
        n.cc[irq_pkg::CC_LO] = take_lvl[0];
        n.vec_addr = irq_pkg::VEC_FIRST -
                     {{(15-VW){1'b0}}, take_v, 1'b0};
      end
      n.vec_v = 1'b1;
    end
    n.halted = n.st == irq_pkg::st_halt;
    n.waiting = n.st == irq_pkg::st_wait;
  end

  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      s <= '0;
      s.ispr <= '1;
      s.cc <= irq_pkg::CC_RESET;
      s.st <= irq_pkg::st_reset;
    end else begin
      s <= n;
    end
  end

  assign reg_rdata = s.rdata;
  assign condition_code_reg = s.cc;
  assign vector_addr = s.vec_addr;
  assign vector_valid = s.vec_v;
  assign restore_valid = s.rest_v;
  assign restore_pc = s.rest_pc;
  assign restore_x = s.rest_x;
  assign restore_a = s.rest_a;
  assign halted = s.halted;
  assign waiting = s.waiting;

  default clocking cb @(posedge mclk);
  endclocking
  default disable iff (!rstn);

  sequence trap_request;
    s.st == irq_pkg::st_run && trap_exec;
  endsequence
  sequence trap_vector;
    vector_valid && vector_addr == irq_pkg::VEC_TRAP &&
      {condition_code_reg[irq_pkg::CC_HI],
       condition_code_reg[irq_pkg::CC_LO]} == irq_pkg::LVL_3;
  endsequence

  chk_reset_vector: assert property (
    s.st == irq_pkg::st_reset |=> vector_valid &&
      vector_addr == irq_pkg::VEC_RESET && cur_lvl == irq_pkg::LVL_3)
    else $error("reset vector not loaded at level three");
  chk_trap_entry: assert property (trap_request |=> trap_vector)
    else $error("trap entry wrong");
  chk_entry_level: assert property (
    take_mask |=> vector_valid && cur_lvl == $past(take_lvl) &&
      vector_addr == irq_pkg::VEC_FIRST -
        {{(15-VW){1'b0}}, $past(take_v), 1'b0})
    else $error("entry level or vector wrong");
  chk_level0_kept: assert property (
    reg_wr && reg_addr == irq_pkg::A_ISPR0 &&
      reg_wdata[1:0] == irq_pkg::LVL_0 |=> s.ispr[0] == $past(s.ispr[0]))
    else $error("level zero write stored");
  chk_interrupt_return_restore: assert property (
    s.st == irq_pkg::st_run && interrupt_return_exec && !trap_exec && s.sp != '0
      |=> restore_valid && condition_code_reg == $past(top_ctx[7:0]) &&
          s.sp == $past(s.sp) - SPW'(1))
    else $error("return did not restore context");
  chk_wait_end: assert property (
    s.st == irq_pkg::st_run && !instr_end && !trap_exec |=> !vector_valid)
    else $error("entry before instruction end");
  chk_higher_only: assert property (
    take_mask |-> rank(take_lvl) > rank(cur_lvl) && pend[take_v])
    else $error("maskable taken without higher level");
  chk_halt_capable: assert property (
    s.st == irq_pkg::st_halt && take_mask |-> HALT_CAP[take_v] ##1 !halted)
    else $error("halt left by incapable source");
  chk_stack_push: assert property (
    (take_mask || take_trap) && s.sp < SPW'(STACK_DEPTH)
      |=> s.sp == $past(s.sp) + SPW'(1) &&
          s.stk[$past(s.sp)] == {$past(pc_in), $past(x_in),
                                 $past(a_in), $past(s.cc)})
    else $error("context not stacked");
endmodule // nested_priority_interrupt_ctrl

/* test/cpu_model.sv */
// Purpose: Core-side stand-in that ends instructions and offers context.
// Assumes: One instruction boundary every four cycles out of reset.
// Notes: Context values are fixed so that returns can be checked exactly.
`timescale 1ns/1ns
module cpu_model #(
  parameter logic [15:0] PC_VAL = 16'hC0DE,
  parameter logic [7:0] X_VAL = 8'h5A,
  parameter logic [7:0] A_VAL = 8'hA5
) (
  input wire logic mclk, // system clock
  input wire logic rstn, // async reset, active low
  output logic instr_end, // instruction boundary pulse
  output logic [15:0] pc_in, // program counter offered
  output logic [7:0] x_in, // index register offered
  output logic [7:0] a_in // accumulator offered
);
  logic [1:0] cnt_r;
  assign pc_in = PC_VAL;
  assign x_in = X_VAL;
  assign a_in = A_VAL;
  // Multi-cycle instructions give latched requests time to be seen.
  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      cnt_r <= 2'h0;
      instr_end <= 1'b0;
    end else begin
      cnt_r <= cnt_r + 2'h1;
      instr_end <= (cnt_r == 2'h3);
    end
  end
endmodule // cpu_model

/* test/tb_nested_priority_interrupt_ctrl.sv */
// Purpose: Self-checking bench of the nested interrupt controller.
// Assumes: Core model ends an instruction every fourth cycle.
// Notes: Each scenario is one task; waits are bounded.
`timescale 1ns/1ns
module tb_nested_priority_interrupt_ctrl;
  localparam logic [15:0] PC_VAL = 16'hC0DE;
  logic mclk, rstn, reg_wr, reg_rd, trap_exec, interrupt_return_exec, cc_wr;
  logic halt_enter, wait_enter, instr_end, vector_valid, restore_valid;
  logic halted, waiting;
  logic [3:0] reg_addr;
  logic [7:0] reg_wdata, reg_rdata, cc_wdata, x_in, a_in;
  logic [7:0] condition_code_reg, restore_x, restore_a;
  logic [15:0] pc_in, ext_pins, vector_addr, restore_pc;
  logic [13:0] periph_flag, periph_en, periph_clear;
  int mismatches, checks_done;

  nested_priority_interrupt_ctrl DUT (.mclk, .rstn, .reg_addr, .reg_wdata,
    .reg_wr, .reg_rd, .reg_rdata, .instr_end, .trap_exec, .interrupt_return_exec,
    .cc_wr, .cc_wdata, .halt_enter, .wait_enter, .pc_in, .x_in, .a_in,
    .ext_pins, .periph_flag, .periph_en, .periph_clear,
    .condition_code_reg, .vector_addr, .vector_valid, .restore_valid,
    .restore_pc, .restore_x, .restore_a, .halted, .waiting);
  cpu_model #(.PC_VAL(PC_VAL)) core_side (.mclk, .rstn, .instr_end,
    .pc_in, .x_in, .a_in);

  always #20 mclk = ~mclk;

  task automatic results();
    $display("Checks %0d, mismatches %0d", checks_done, mismatches);
    if (mismatches == 0 && checks_done > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask

  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    checks_done++;
    if (got !== exp) begin
      mismatches++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic wr(input logic [3:0] a, input logic [7:0] d);
    @(posedge mclk);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    @(posedge mclk);
    reg_wr <= 1'b0;
  endtask

  task automatic rd_chk(input logic [3:0] a, input logic [7:0] exp);
    @(posedge mclk);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge mclk);
    reg_rd <= 1'b0;
    #1;
    chk({8'h00, reg_rdata}, {8'h00, exp});
  endtask

  // Codes: 0 trap, 1 return, 2 halt, 3 wait, 4 condition code load.
  task automatic cpu_op(input int op, input logic [7:0] v);
    @(posedge mclk);
    trap_exec <= (op == 0);
    interrupt_return_exec <= (op == 1);
    halt_enter <= (op == 2);
    wait_enter <= (op == 3);
    cc_wr <= (op == 4);
    cc_wdata <= v;
    @(posedge mclk);
    {trap_exec, interrupt_return_exec, halt_enter, wait_enter, cc_wr} <= 5'h00;
  endtask

  // Looks before the first edge so a pulse from the last edge is seen.
  task automatic await(input bit rest);
    for (int i = 0; i < 64; i++) begin
      #1;
      if ((rest ? restore_valid : vector_valid) === 1'b1) begin
        return;
      end
      @(posedge mclk);
    end
    mismatches++;
    results();
  endtask

  // Takes one entry, checks it, clears a peripheral source when v is not negative, and returns from it.
  task automatic serve(input int v, input logic [15:0] va,
                       input logic [1:0] lvl, input logic [7:0] cc);
    await(1'b0);
    chk(vector_addr, va);
    chk({14'h0000, condition_code_reg[5], condition_code_reg[3]},
        {14'h0000, lvl});
    @(posedge mclk);
    if (v >= 0) begin
      periph_flag[v] <= 1'b0;
      periph_clear[v] <= 1'b1;
    end
    @(posedge mclk);
    periph_clear <= 14'h0000;
    cpu_op(1, 8'h00);
    await(1'b1);
    chk(restore_pc, PC_VAL);
    chk({restore_x, restore_a}, 16'h5AA5);
    chk({8'h00, condition_code_reg}, {8'h00, cc});
  endtask

  task automatic t_reset();
    chk({8'h00, condition_code_reg}, {8'h00, irq_pkg::CC_RESET});
    @(posedge mclk);
    rstn <= 1'b1;
    await(1'b0);
    chk(vector_addr, irq_pkg::VEC_RESET);
    chk({14'h0000, condition_code_reg[5], condition_code_reg[3]},
        16'h0003);
    for (int i = 0; i < 4; i++) begin
      rd_chk(4'(i), irq_pkg::ISPR_RESET);
    end
  endtask

  task automatic t_regs();
    wr(irq_pkg::A_ISPR0, 8'hCF);
    wr(irq_pkg::A_ISPR0, 8'h64);
    rd_chk(irq_pkg::A_ISPR0, 8'h44);
    wr(4'h3, 8'h00);
    rd_chk(4'h3, 8'hF0);
    rd_chk(4'hD, 8'h00);
    wr(4'h3, 8'hFF);
  endtask

  task automatic t_arb();
    wr(irq_pkg::A_ISPR0, 8'hF1);
    wr(4'h1, 8'h5F);
    @(posedge mclk);
    periph_en <= 14'h3FFF;
    periph_flag[1:0] <= 2'h3;
    rd_chk(irq_pkg::A_PEND_LO, 8'h03);
    cpu_op(4, 8'hE2);
    serve(1, 16'hFFF8, irq_pkg::LVL_2, 8'hE2);
    serve(0, 16'hFFFA, irq_pkg::LVL_1, 8'hE2);
    @(posedge mclk);
    periph_flag[7:6] <= 2'h3;
    serve(6, 16'hFFEE, irq_pkg::LVL_1, 8'hE2);
    serve(7, 16'hFFEC, irq_pkg::LVL_1, 8'hE2);
  endtask

  task automatic t_mask();
    cpu_op(4, 8'hEA);
    periph_en[10] <= 1'b0;
    periph_flag[10] <= 1'b1;
    rd_chk(irq_pkg::A_PEND_HI, 8'h00);
    periph_en[10] <= 1'b1;
    rd_chk(irq_pkg::A_PEND_HI, 8'h04);
    periph_flag[10] <= 1'b0;
    rd_chk(irq_pkg::A_PEND_HI, 8'h04);
    periph_clear[10] <= 1'b1;
    @(posedge mclk);
    periph_clear[10] <= 1'b0;
    rd_chk(irq_pkg::A_PEND_HI, 8'h00);
  endtask

  task automatic t_halt();
    periph_flag[9] <= 1'b1;
    wr(irq_pkg::A_EXT_INT_SENSITIVITY_CTRL, 8'h01);
    wr(irq_pkg::A_PSEL0, 8'h03);
    cpu_op(2, 8'h00);
    repeat (8) @(posedge mclk);
    #1;
    chk({15'h0000, halted}, 16'h0001);
    @(posedge mclk);
    ext_pins[1] <= 1'b1;
    serve(-1, 16'hFFF6, irq_pkg::LVL_3, 8'hE2);
    chk({15'h0000, halted}, 16'h0000);
    serve(9, 16'hFFE8, irq_pkg::LVL_3, 8'hE2);
    repeat (12) begin
      @(posedge mclk);
      #1;
      chk({15'h0000, vector_valid}, 16'h0000);
    end
  endtask

  task automatic t_wait();
    cpu_op(3, 8'h00);
    periph_flag[9] <= 1'b1;
    serve(9, 16'hFFE8, irq_pkg::LVL_3, 8'hE2);
    chk({15'h0000, waiting}, 16'h0000);
    cpu_op(0, 8'h00);
    serve(-1, irq_pkg::VEC_TRAP, irq_pkg::LVL_3, 8'hE2);
  endtask

  initial begin
    mclk = 1'b0;
    rstn = 1'b0;
    {reg_wr, reg_rd, trap_exec, interrupt_return_exec, cc_wr} = 5'h00;
    {halt_enter, wait_enter} = 2'h0;
    reg_addr = 4'h0;
    reg_wdata = 8'h00;
    cc_wdata = 8'h00;
    ext_pins = 16'h0000;
    periph_flag = 14'h0000;
    periph_en = 14'h0000;
    periph_clear = 14'h0000;
    mismatches = 0;
    checks_done = 0;
    repeat (16) @(posedge mclk);
    t_reset();
    t_regs();
    t_arb();
    t_mask();
    t_halt();
    t_wait();
    // A second reset while halted must restart at the reset vector.
    cpu_op(2, 8'h00);
    rstn <= 1'b0;
    @(posedge mclk);
    t_reset();
    chk({15'h0000, halted}, 16'h0000);
    results();
  end
endmodule // tb_nested_priority_interrupt_ctrl
